// ===== core/list_trigger_command_handler.sv
// Notes on behaviour
// - Segment-kind query answers 01 for looping, 00 for first-pass-only.
// - Sample pulse width accepted only from 0.00025 to 0.034 seconds.
// - Second sample-width setting posts command error -100.
// - Sample-width query before any width stored posts command error.
// - Store name is 1 to 9 characters, no spaces, lower case raised.
// - Store slot number must be 1 through 16.
// - Store keeps up to ten segments, loop count and protection limits.
// - Trigger setup turns flag pins into trigger output until list clear.
// - Trigger pulse width must lie between 0.00025 and 0.034 seconds.
// - During pulse flag conducts when polarity on, off when polarity off.
// - Trigger-width query before any width stored posts command error.
// - Wait time-out accepts 0.00025 to 0.034 seconds.
// - Unset time-out stays 0, meaning unlimited, and reads back 0.
// - Triggered point sets output level and pulses flag for stored width.
// - Triggered point without stored trigger width posts error -221.
// - Triggered point needs an earlier voltage entry and no current entries, else -221.
// - Dwell list length differing from value list posts error -226; the code checks it only when a triggered point is written.
// - Voltage points append from location 0 up to configured maximum.
// - Voltage append or readback with current entries posts error -221.
// - Readback returns up to 16 values from chosen start location.
// - First-pass segments run on first count only; last always loops.
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "list_trigger_consts.svh"

module list_trigger_command_handler
  import list_trigger_pkg::*;
#(
  parameter int LIST_DEPTH = 5900
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [1:0] cap_sel_in,
  input wire logic [7:0] segments_built_in,
  input wire logic [15:0] protect_limit_in,
  input wire logic output_off_in,
  input wire logic seg_looped_in,
  input wire logic first_count_in,
  input wire logic last_segment_in,
  output logic [31:0] rdata_out,
  output logic flag_on_out,
  output logic [15:0] level_out,
  output logic level_stb_out,
  output logic seg_en_out
);

  state_type cur;
  state_type next;
  logic [15:0] list_mem [LIST_DEPTH];
  slot_type slot_mem [16];
  logic mem_we;
  logic slot_we;
  logic [3:0] slot_idx;
  slot_type slot_word;
  logic err_new;
  logic [15:0] err_code;
  logic [12:0] cap;
  logic [7:0] seg_keep;
  logic [7:0] name_ch;
  logic samp_ok;
  logic wait_ok;
  logic trig_ok;

  // Width checks on the low half of the write data
  assign samp_ok = (wdata_in[15:0] >= `WIDTH_MIN_US) && (wdata_in[15:0] <= `WIDTH_MAX_US);
  assign wait_ok = samp_ok;
  assign trig_ok = samp_ok;

  // Capacity is the smaller of configuration and physical depth
  always_comb
  begin
    case (cap_sel_in)
      2'b00: cap = `CAP_SMALL;
      2'b01: cap = `CAP_MID;
      default: cap = `CAP_LARGE;
    endcase
    if (cap > 13'(LIST_DEPTH))
    begin
      cap = 13'(LIST_DEPTH);
    end
  end

  // Only the first ten segments survive a store
  assign seg_keep = (segments_built_in > `SEG_SAVE_MAX) ? `SEG_SAVE_MAX : segments_built_in;
  // Lower case raised before it enters the name buffer
  assign name_ch = ((wdata_in[7:0] >= 8'h61) && (wdata_in[7:0] <= 8'h7a)) ?
                   (wdata_in[7:0] - 8'h20) : wdata_in[7:0];

  // Next-state logic for commands, queries and the trigger pulse
  always_comb
  begin
    next = cur;
    next.rdata = 32'h0000_0000;
    next.level_stb = 1'b0;
    mem_we = 1'b0;
    slot_we = 1'b0;
    slot_idx = 4'h0;
    slot_word = '0;
    err_new = 1'b0;
    err_code = `ERR_NONE;
    // Commands are taken one per strobe, so order is arrival order
    if (wr_in)
    begin
      case (addr_in)
        `ADDR_SEGMENT: next.looping = wdata_in[0];
        `ADDR_SAMPLE:
        begin
          if (cur.samp_set || !samp_ok)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            next.samp_set = 1'b1;
            next.samp_us = wdata_in[15:0];
          end
        end
        `ADDR_TRIGGER:
        begin
          if (!trig_ok)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            next.trig_set = 1'b1;
            next.trig_us = wdata_in[15:0];
            next.trig_pol = wdata_in[`TRIG_POL_BIT];
            next.trig_mode = 1'b1;
          end
        end
        `ADDR_WAIT:
        begin
          if (!wait_ok)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            next.wait_us = wdata_in[15:0];
          end
        end
        `ADDR_CLEAR:
        begin
          // Clear empties the lists and gives the pins back to the flag
          next.volt_cnt = 13'h0000;
          next.curr_cnt = 13'h0000;
          next.dwell_cnt = 13'h0000;
          next.read_ptr = 13'h0000;
          next.read_left = 5'h00;
          next.trig_mode = 1'b0;
          next.pstate = PULSE_IDLE;
          next.pulse_cnt = 20'h0_0000;
        end
        `ADDR_VOLT_PT, `ADDR_TRIG_PT:
        begin
          if (cur.curr_cnt != 13'h0000)
          begin
            err_new = 1'b1;
            err_code = `ERR_CONFLICT;
          end
          else if ((addr_in == `ADDR_TRIG_PT) && !cur.trig_set)
          begin
            err_new = 1'b1;
            err_code = `ERR_CONFLICT;
          end
          else if ((addr_in == `ADDR_TRIG_PT) && (cur.volt_cnt == 13'h0000))
          begin
            err_new = 1'b1;
            err_code = `ERR_CONFLICT;
          end
          else if ((addr_in == `ADDR_TRIG_PT) && (cur.dwell_cnt != cur.volt_cnt))
          begin
            err_new = 1'b1;
            err_code = `ERR_LENGTH;
          end
          else if (cur.volt_cnt >= cap)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            mem_we = 1'b1;
            next.volt_cnt = cur.volt_cnt + 13'h0001;
            if (addr_in == `ADDR_TRIG_PT)
            begin
              // Triggered point also owns its dwell slot
              next.dwell_cnt = cur.dwell_cnt + 13'h0001;
              next.level = wdata_in[15:0];
              next.level_stb = 1'b1;
              next.pstate = PULSE_ACTIVE;
              next.pulse_cnt = 20'(cur.trig_us) * 20'(`CYC_PER_US) - 20'h0_0001;
            end
          end
        end
        `ADDR_CURR_PT:
        begin
          if (cur.volt_cnt != 13'h0000)
          begin
            err_new = 1'b1;
            err_code = `ERR_CONFLICT;
          end
          else if (cur.curr_cnt < cap)
          begin
            next.curr_cnt = cur.curr_cnt + 13'h0001;
          end
        end
        `ADDR_DWELL_PT:
        begin
          if (cur.dwell_cnt < cap)
          begin
            next.dwell_cnt = cur.dwell_cnt + 13'h0001;
          end
        end
        `ADDR_READ_START:
        begin
          next.read_ptr = wdata_in[12:0];
          next.read_left = `READ_BURST;
        end
        `ADDR_NAME_CHAR:
        begin
          if (wdata_in[0] && wdata_in[7:1] == 7'h00)
          begin
            // Odd value 1 restarts the name
            next.name_len = 4'h0;
            next.name = 72'h0;
          end
          else if ((name_ch == 8'h20) || (cur.name_len >= `NAME_MAX))
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            next.name = {cur.name[63:0], name_ch};
            next.name_len = cur.name_len + 4'h1;
          end
        end
        `ADDR_SAVE:
        begin
          if ((wdata_in[4:0] == 5'h00) || (wdata_in[4:0] > `SLOT_MAX))
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else if (wdata_in[`SAVE_SELECT_BIT])
          begin
            next.slot_view = wdata_in[4:0];
          end
          else if (cur.name_len == 4'h0)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            slot_we = 1'b1;
            slot_idx = 4'(wdata_in[4:0] - 5'h01);
            slot_word = '{seg: seg_keep, loops: cur.loop_cnt, limit: protect_limit_in,
                          name: cur.name};
            next.slot_view = wdata_in[4:0];
          end
        end
        `ADDR_LOOP_COUNT: next.loop_cnt = wdata_in[15:0];
        default: next.looping = cur.looping;
      endcase
    end
    // Queries answer in the following cycle only
    if (rd_in)
    begin
      case (addr_in)
        `ADDR_SEGMENT: next.rdata = {31'h0000_0000, cur.looping};
        `ADDR_SAMPLE:
        begin
          if (!cur.samp_set)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            next.rdata = {16'h0000, cur.samp_us};
          end
        end
        `ADDR_TRIGGER:
        begin
          if (!cur.trig_set)
          begin
            err_new = 1'b1;
            err_code = `ERR_COMMAND;
          end
          else
          begin
            next.rdata = {15'h0000, cur.trig_pol, cur.trig_us};
          end
        end
        `ADDR_WAIT: next.rdata = {16'h0000, cur.wait_us};
        `ADDR_READ_DATA:
        begin
          if (cur.curr_cnt != 13'h0000)
          begin
            err_new = 1'b1;
            err_code = `ERR_CONFLICT;
          end
          else if ((cur.read_left != 5'h00) && (cur.read_ptr < cur.volt_cnt))
          begin
            next.rdata = {16'h0000, list_mem[cur.read_ptr]};
            next.read_ptr = cur.read_ptr + 13'h0001;
            next.read_left = cur.read_left - 5'h01;
          end
        end
        `ADDR_POINTS: next.rdata = {19'h0_0000, cur.volt_cnt};
        `ADDR_SAVE:
        begin
          if (cur.slot_view != 5'h00)
          begin
            next.rdata = {8'h00, slot_mem[4'(cur.slot_view - 5'h01)].seg,
                          slot_mem[4'(cur.slot_view - 5'h01)].loops};
          end
        end
        `ADDR_NAME_CHAR:
        begin
          if (cur.slot_view != 5'h00)
          begin
            next.rdata = slot_mem[4'(cur.slot_view - 5'h01)].name[31:0];
          end
        end
        `ADDR_LOOP_COUNT: next.rdata = {16'h0000, cur.loop_cnt};
        `ADDR_ERROR: next.rdata = {16'h0000, cur.err};
        default: next.rdata = 32'h0000_0000;
      endcase
    end
    // Reading the error clears it, but a fresh error wins
    if (rd_in && (addr_in == `ADDR_ERROR))
    begin
      next.err = `ERR_NONE;
    end
    if (err_new)
    begin
      next.err = err_code;
    end
    // Trigger pulse timer
    case (cur.pstate)
      PULSE_IDLE:
      begin
        // Leave pulse_cnt alone, a triggered point may have just loaded it
      end
      PULSE_ACTIVE:
      begin
        if (next.pstate == PULSE_ACTIVE && !(wr_in && addr_in == `ADDR_TRIG_PT && mem_we))
        begin
          if (cur.pulse_cnt == 20'h0_0000)
          begin
            next.pstate = PULSE_IDLE;
          end
          else
          begin
            next.pulse_cnt = cur.pulse_cnt - 20'h0_0001;
          end
        end
      end
      default: next.pstate = PULSE_IDLE;
    endcase
    // Flag pin drive follows mode and pulse state
    if (cur.pstate == PULSE_ACTIVE)
    begin
      next.flag_on = cur.trig_pol;
    end
    else if (cur.trig_mode)
    begin
      next.flag_on = !cur.trig_pol;
    end
    else
    begin
      next.flag_on = output_off_in;
    end
    // Last segment always loops; first-pass ones only on count one
    next.seg_en = last_segment_in || seg_looped_in || first_count_in;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cur <= '0;
      cur.wait_us <= `WAIT_RESET_US;
      cur.err <= `ERR_NONE;
      cur.pstate <= PULSE_IDLE;
    end
    else if (ce_in)
    begin
      cur <= next;
    end
  end

  // List and slot memories carry no reset to stay RAM-friendly
  always_ff @(posedge clk_in)
  begin
    if (ce_in && mem_we)
    begin
      list_mem[cur.volt_cnt] <= wdata_in[15:0];
    end
    if (ce_in && slot_we)
    begin
      slot_mem[slot_idx] <= slot_word;
    end
  end

  assign rdata_out = cur.rdata;
  assign flag_on_out = cur.flag_on;
  assign level_out = cur.level;
  assign level_stb_out = cur.level_stb;
  assign seg_en_out = cur.seg_en;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_seg_code: assert property (ce_in && rd_in && addr_in == `ADDR_SEGMENT |=>
    rdata_out == {31'h0000_0000, $past(cur.looping)})
    else $error("segment kind answer wrong");
  chk_samp_range: assert property (cur.samp_set |->
    cur.samp_us >= `WIDTH_MIN_US && cur.samp_us <= `WIDTH_MAX_US)
    else $error("sample width out of range");
  chk_samp_twice: assert property (ce_in && wr_in && addr_in == `ADDR_SAMPLE && cur.samp_set
    |=> cur.err == `ERR_COMMAND && $stable(cur.samp_us))
    else $error("repeat sample width not refused");
  chk_samp_unset: assert property (ce_in && rd_in && addr_in == `ADDR_SAMPLE && !cur.samp_set
    |=> cur.err == `ERR_COMMAND && rdata_out == 32'h0000_0000)
    else $error("unset sample query not refused");
  chk_trig_noset: assert property (ce_in && wr_in && addr_in == `ADDR_TRIG_PT && !cur.trig_set
    && cur.curr_cnt == 13'h0000 |=> cur.err == `ERR_CONFLICT && $stable(cur.volt_cnt))
    else $error("triggered point without width accepted");
  chk_clear_flag: assert property (ce_in && wr_in && addr_in == `ADDR_CLEAR |=>
    !cur.trig_mode && cur.volt_cnt == 13'h0000 ##1 ce_in [*1] |=> flag_on_out == $past(output_off_in))
    else $error("clear did not restore flag");
  chk_pulse_pol: assert property (ce_in && cur.pstate == PULSE_ACTIVE |=>
    flag_on_out == $past(cur.trig_pol))
    else $error("pulse polarity wrong");
  chk_pulse_start: assert property (ce_in && wr_in && addr_in == `ADDR_TRIG_PT && mem_we |=>
    cur.pstate == PULSE_ACTIVE && level_stb_out && level_out == $past(wdata_in[15:0]))
    else $error("triggered point did not start pulse");
  chk_wait_read: assert property (ce_in && rd_in && addr_in == `ADDR_WAIT |=>
    rdata_out == {16'h0000, $past(cur.wait_us)})
    else $error("wait query wrong");
  chk_volt_append: assert property (ce_in && wr_in && addr_in == `ADDR_VOLT_PT
    && cur.curr_cnt != 13'h0000 |=> cur.err == `ERR_CONFLICT && $stable(cur.volt_cnt))
    else $error("voltage append with current list accepted");

  cov_pulse: cover property (cur.pstate == PULSE_ACTIVE ##1 cur.pstate == PULSE_IDLE);
  cov_save: cover property (ce_in && slot_we);
  cov_twice: cover property (ce_in && wr_in && addr_in == `ADDR_SAMPLE && cur.samp_set);
  cov_length: cover property (cur.err == `ERR_LENGTH);

endmodule // list_trigger_command_handler

// ===== dv/flag_instrument.sv
`timescale 1ns/1ps

// External instrument on the flag pins: times each active run of the flag
module flag_instrument (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flag_in,
  input wire logic active_in,
  output logic [19:0] run_len_out,
  output logic [7:0] n_runs_out
);
  logic [19:0] count;

  // Count active cycles, latch length when the flag returns to idle
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= 20'h0_0000;
      run_len_out <= 20'h0_0000;
      n_runs_out <= 8'h00;
    end
    else if (flag_in == active_in)
    begin
      count <= count + 20'h0_0001;
    end
    else if (count != 20'h0_0000)
    begin
      run_len_out <= count;
      n_runs_out <= n_runs_out + 8'h01;
      count <= 20'h0_0000;
    end
  end
endmodule // flag_instrument

// ===== dv/testbench.sv
`timescale 1ns/1ps
`include "list_trigger_consts.svh"

`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end

module testbench;
  import list_trigger_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [1:0] cap_sel_in = 2'h0;
  logic [7:0] segments_built_in = 8'h0c;
  logic [15:0] protect_limit_in = 16'h00aa;
  logic output_off_in = 1'b1;
  logic seg_looped_in = 1'b0;
  logic first_count_in = 1'b0;
  logic last_segment_in = 1'b0;
  logic [31:0] rdata_out;
  logic flag_on_out;
  logic [15:0] level_out;
  logic level_stb_out;
  logic seg_en_out;
  logic active = 1'b1;
  logic [19:0] run_len;
  logic [7:0] n_runs;
  logic [7:0] runs_before;
  int n_checks = 0;
  int n_mismatch = 0;

  list_trigger_command_handler list_trigger_command_handler_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .cap_sel_in(cap_sel_in),
    .segments_built_in(segments_built_in), .protect_limit_in(protect_limit_in),
    .output_off_in(output_off_in), .seg_looped_in(seg_looped_in),
    .first_count_in(first_count_in), .last_segment_in(last_segment_in),
    .rdata_out(rdata_out), .flag_on_out(flag_on_out), .level_out(level_out),
    .level_stb_out(level_stb_out), .seg_en_out(seg_en_out));

  flag_instrument flag_instrument_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .flag_in(flag_on_out), .active_in(active),
    .run_len_out(run_len), .n_runs_out(n_runs));

  // 20 MHz clock
  initial
  begin
    forever #25 clk_in = ~clk_in;
  end

  // One-cycle write strobe, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stands only in the cycle after the taking edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_out)
  endtask

  // Error slot read clears it, so every refusal is checked exactly once
  task automatic er(input logic [15:0] e);
    rd(`ADDR_ERROR, {16'h0000, e});
  endtask

  task automatic settle(input logic e);
    repeat (3) @(posedge clk_in);
    #1;
    `CHK("flag", e, flag_on_out)
  endtask

  // Triggered point, then time the pulse at the instrument
  task automatic trig_point(input logic [15:0] v);
    int i;
    wr(`ADDR_TRIG_PT, {16'h0000, v});
    // Taken after the write so a run closed by a polarity swap is not seen as the pulse
    #1;
    runs_before = n_runs;
    for (i = 0; i < 4 && level_stb_out !== 1'b1; i++)
    begin
      @(posedge clk_in);
      #1;
    end
    `CHK("level_stb", 1'b1, level_stb_out)
    `CHK("level", v, level_out)
    for (i = 0; i < 6000 && n_runs === runs_before; i++)
    begin
      @(posedge clk_in);
    end
    #1;
    `CHK("pulse_len", 20'd5000, run_len)
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog well above the expected sixteen thousand cycles
  initial
  begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    int i;
    int k;
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(`ADDR_WAIT, 32'h0000_0000);
    rd(`ADDR_SAMPLE, 32'h0000_0000);
    er(`ERR_COMMAND);
    rd(`ADDR_TRIGGER, 32'h0000_0000);
    er(`ERR_COMMAND);
    settle(1'b1);
    wr(`ADDR_SEGMENT, 32'h0000_0001);
    rd(`ADDR_SEGMENT, 32'h0000_0001);
    wr(`ADDR_SEGMENT, 32'h0000_0000);
    rd(`ADDR_SEGMENT, 32'h0000_0000);
    $display("test reset and segment done");

    wr(`ADDR_SAMPLE, 32'h0000_00f9);
    er(`ERR_COMMAND);
    wr(`ADDR_SAMPLE, 32'h0000_00fa);
    er(`ERR_NONE);
    wr(`ADDR_SAMPLE, 32'h0000_0100);
    er(`ERR_COMMAND);
    rd(`ADDR_SAMPLE, 32'h0000_00fa);
    wr(`ADDR_WAIT, 32'h0000_84d1);
    er(`ERR_COMMAND);
    wr(`ADDR_WAIT, 32'h0000_84d0);
    rd(`ADDR_WAIT, 32'h0000_84d0);
    $display("test widths done");

    wr(`ADDR_CLEAR, 32'h0000_0000);
    wr(`ADDR_VOLT_PT, 32'h0000_0005);
    wr(`ADDR_DWELL_PT, 32'h0000_0001);
    wr(`ADDR_TRIG_PT, 32'h0000_0007);
    er(`ERR_CONFLICT);
    wr(`ADDR_TRIGGER, 32'h0001_00f9);
    er(`ERR_COMMAND);
    settle(1'b1);
    wr(`ADDR_TRIGGER, 32'h0001_00fa);
    rd(`ADDR_TRIGGER, 32'h0001_00fa);
    settle(1'b0);
    wr(`ADDR_CLEAR, 32'h0000_0000);
    settle(1'b1);
    wr(`ADDR_TRIGGER, 32'h0001_00fa);
    wr(`ADDR_TRIG_PT, 32'h0000_0007);
    er(`ERR_CONFLICT);
    wr(`ADDR_VOLT_PT, 32'h0000_0003);
    wr(`ADDR_TRIG_PT, 32'h0000_0007);
    er(`ERR_LENGTH);
    wr(`ADDR_DWELL_PT, 32'h0000_0001);
    trig_point(16'h1234);
    er(`ERR_NONE);
    wr(`ADDR_TRIGGER, 32'h0000_00fa);
    settle(1'b1);
    active <= 1'b0;
    trig_point(16'h0abc);
    rd(`ADDR_POINTS, 32'h0000_0003);
    $display("test trigger done");

    wr(`ADDR_CLEAR, 32'h0000_0000);
    wr(`ADDR_CURR_PT, 32'h0000_0001);
    wr(`ADDR_VOLT_PT, 32'h0000_0002);
    er(`ERR_CONFLICT);
    rd(`ADDR_READ_DATA, 32'h0000_0000);
    er(`ERR_CONFLICT);
    rd(`ADDR_POINTS, 32'h0000_0000);
    wr(`ADDR_CLEAR, 32'h0000_0000);
    for (i = 0; i < 20; i++)
    begin
      wr(`ADDR_VOLT_PT, 32'h0000_0100 + i);
    end
    wr(`ADDR_READ_START, 32'h0000_0002);
    for (i = 0; i < 16; i++)
    begin
      rd(`ADDR_READ_DATA, 32'h0000_0102 + i);
    end
    rd(`ADDR_READ_DATA, 32'h0000_0000);
    wr(`ADDR_READ_START, 32'h0000_0000);
    rd(`ADDR_READ_DATA, 32'h0000_0100);
    for (i = 20; i < 2950; i++)
    begin
      wr(`ADDR_VOLT_PT, i);
    end
    er(`ERR_NONE);
    wr(`ADDR_VOLT_PT, 32'h0000_0001);
    er(`ERR_COMMAND);
    rd(`ADDR_POINTS, {19'h0_0000, `CAP_SMALL});
    $display("test lists done");

    wr(`ADDR_NAME_CHAR, 32'h0000_0001);
    wr(`ADDR_SAVE, 32'h0000_0003);
    er(`ERR_COMMAND);
    wr(`ADDR_NAME_CHAR, 32'h0000_0020);
    er(`ERR_COMMAND);
    for (i = 0; i < 9; i++)
    begin
      wr(`ADDR_NAME_CHAR, 32'h0000_0061);
    end
    wr(`ADDR_NAME_CHAR, 32'h0000_0061);
    er(`ERR_COMMAND);
    wr(`ADDR_SAVE, 32'h0000_0000);
    er(`ERR_COMMAND);
    wr(`ADDR_SAVE, 32'h0000_0011);
    er(`ERR_COMMAND);
    wr(`ADDR_LOOP_COUNT, 32'h0000_0005);
    rd(`ADDR_LOOP_COUNT, 32'h0000_0005);
    wr(`ADDR_SAVE, 32'h0000_0010);
    er(`ERR_NONE);
    wr(`ADDR_SAVE, 32'h0000_0110);
    rd(`ADDR_SAVE, 32'h000a_0005);
    rd(`ADDR_NAME_CHAR, 32'h4141_4141);
    $display("test save done");

    // Sequencer status combinations
    for (k = 0; k < 8; k++)
    begin
      @(posedge clk_in);
      {last_segment_in, first_count_in, seg_looped_in} <= k[2:0];
      repeat (2) @(posedge clk_in);
      #1;
      `CHK("seg_en", (k != 0), seg_en_out)
    end
    rd(8'h3c, 32'h0000_0000);
    $display("test sequencer done");
    end_of_test();
  end
endmodule // testbench

// ===== inc/list_trigger_consts.svh
`ifndef LIST_TRIGGER_CONSTS_SVH
`define LIST_TRIGGER_CONSTS_SVH
// Register offsets (byte addresses)
`define ADDR_SEGMENT 8'h00
`define ADDR_SAMPLE 8'h04
`define ADDR_TRIGGER 8'h08
`define ADDR_WAIT 8'h0c
`define ADDR_CLEAR 8'h10
`define ADDR_VOLT_PT 8'h14
`define ADDR_CURR_PT 8'h18
`define ADDR_TRIG_PT 8'h1c
`define ADDR_DWELL_PT 8'h20
`define ADDR_READ_START 8'h24
`define ADDR_READ_DATA 8'h28
`define ADDR_POINTS 8'h2c
`define ADDR_SAVE 8'h30
`define ADDR_NAME_CHAR 8'h34
`define ADDR_LOOP_COUNT 8'h38
`define ADDR_ERROR 8'h40
// Field positions
`define TRIG_POL_BIT 16
`define SAVE_SELECT_BIT 8
// Durations in microseconds
`define WIDTH_MIN_US 16'h00fa
`define WIDTH_MAX_US 16'h84d0
`define WAIT_RESET_US 16'h0000
// Clock rate and derived cycles per microsecond
`define CLK_HZ 20000000
`define CYC_PER_US (`CLK_HZ / 1000000)
// List capacities per configuration, then read burst, name, slot and saved-segment limits
`define CAP_SMALL 13'h0b86
`define CAP_MID 13'h0f5d
`define CAP_LARGE 13'h170c
`define READ_BURST 5'h10
`define NAME_MAX 4'h9
`define SLOT_MAX 5'h10
`define SEG_SAVE_MAX 8'h0a
// Error codes, two's complement
`define ERR_NONE 16'h0000
`define ERR_COMMAND 16'hff9c
`define ERR_CONFLICT 16'hff23
`define ERR_LENGTH 16'hff1e
`endif

// ===== inc/list_trigger_pkg.sv
package list_trigger_pkg;
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b01,
    PULSE_ACTIVE = 2'b10
  } pulse_state_type;

  typedef struct packed {
    logic [7:0] seg;
    logic [15:0] loops;
    logic [15:0] limit;
    logic [71:0] name;
  } slot_type;

  typedef struct packed {
    logic looping;
    logic samp_set;
    logic [15:0] samp_us;
    logic trig_set;
    logic [15:0] trig_us;
    logic trig_pol;
    logic trig_mode;
    logic [15:0] wait_us;
    logic [12:0] volt_cnt;
    logic [12:0] curr_cnt;
    logic [12:0] dwell_cnt;
    logic [12:0] read_ptr;
    logic [4:0] read_left;
    logic [15:0] loop_cnt;
    logic [71:0] name;
    logic [3:0] name_len;
    logic [4:0] slot_view;
    logic [15:0] err;
    logic [31:0] rdata;
    logic flag_on;
    logic [15:0] level;
    logic level_stb;
    logic seg_en;
    logic [19:0] pulse_cnt;
    pulse_state_type pstate;
  } state_type;
endpackage
